// ===== hw/pck_pkg.sv
package pck_pkg;

  // Register byte offsets
  localparam logic [4:0] PCK_OFS_CTRL = 5'h00;
  localparam logic [4:0] PCK_OFS_PROTECT = 5'h04;
  localparam logic [4:0] PCK_OFS_BITOP = 5'h08;
  localparam logic [4:0] PCK_OFS_STATUS = 5'h0C;

  // Control register field positions
  localparam int PCK_BIT_SUB_FB_OFF = 7;
  localparam int PCK_BIT_MAIN_OSC_STOP = 6;
  localparam int PCK_BIT_MAIN_FB_OFF = 5;
  localparam int PCK_BIT_ON_SUB = 4;
  localparam int PCK_BIT_SUB_SEL = 3;
  localparam int PCK_DIV_LSB = 0;
  localparam int PCK_DIV_W = 3;

  // Bit access register fields
  localparam int PCK_BITOP_VAL = 3;

  // Status register fields
  localparam int PCK_ST_REFUSED = 0;
  localparam int PCK_ST_PENDING = 1;
  localparam int PCK_ST_OSC_OFF = 2;

  // Reset value of the control register
  localparam logic [7:0] PCK_CTRL_RESET = 8'h03;

  // Divider codes 6 and 7 are prohibited
  localparam logic [2:0] PCK_DIV_MAX = 3'h5;
  localparam int PCK_DIV_CNT_W = 5;

  // AXI responses
  localparam logic [1:0] PCK_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCK_RESP_SLVERR = 2'h2;

endpackage

// ===== hw/pck_divider.sv
`timescale 1ns/1ps
`default_nettype none

module pck_divider
  import pck_pkg::*;
#(
  parameter int CNT_W = PCK_DIV_CNT_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Selection
  input wire logic [2:0] div_code,
  input wire logic use_sub,
  input wire logic sub_edge,
  // Internal system clock enable
  output logic sys_clk_en
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mask;

  // Terminal count for a power-of-two division
  function automatic logic [CNT_W-1:0] div_mask(input logic [2:0] code);
    div_mask = CNT_W'((32'h1 << code) - 32'h1);
  endfunction

  assign mask = div_mask(div_code);

  // Free-running prescaler count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if ((cnt_q & mask) == mask) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // Main clock divided by 1..32, or one pulse per subclock period
  assign sys_clk_en = ce && (use_sub ? sub_edge : ((cnt_q & mask) == mask));

  a_div_by_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !use_sub && div_code == 3'h0) |-> sys_clk_en)
    else $error("undivided main clock did not pulse every cycle");

endmodule

`default_nettype wire

// ===== hw/pck_switch.sv
`timescale 1ns/1ps
`default_nettype none

module pck_switch (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Request and subclock level
  input wire logic sub_sel,
  input wire logic sub_clk,
  // Source status
  output logic cpu_on_sub,
  output logic sub_edge
);

  logic sub_prev_q;
  logic src_q;

  // Subclock input is synchronous, so a plain delay gives its edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_prev_q <= 1'b0;
    end else if (ce) begin
      sub_prev_q <= sub_clk;
    end
  end

  assign sub_edge = sub_clk && !sub_prev_q;

  // Source changes only on a subclock edge, so at most one subclock period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= 1'b0;
    end else if (ce && sub_edge) begin
      src_q <= sub_sel;
    end
  end

  assign cpu_on_sub = src_q;

  a_switch_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && sub_edge) |=> (src_q == $past(sub_sel)))
    else $error("clock source not switched at subclock edge");

  a_switch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !(ce && sub_edge) |=> $stable(src_q))
    else $error("clock source changed between subclock edges");

endmodule

`default_nettype wire

// ===== hw/pck_clock_ctrl.sv
// How it works
// - Control writes take effect only right after a protect-register unlock write.
// - Byte writes and single-bit writes are supported; a bit write touches one bit.
// - Reset loads the control register with 03H: main clock divided by eight.
// - Bit 7 at 0 enables the subclock feedback resistor, at 1 disables it.
// - Main oscillator stops in STOP mode, or with stop bit set while on subclock.
// - Divider codes 0..5 give main clock /1../32; 11x refused; select bit picks subclock.
// - Source switch completes within one subclock period; status bit 4 then follows.
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pck_clock_ctrl
  import pck_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // Clock, reset and clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Chip state and subclock level
  input wire logic stop_mode,
  input wire logic sub_clk,
  // Clock control outputs
  output logic sys_clk_en,
  output logic cpu_clock_is_sub,
  output logic main_osc_stop_out,
  output logic main_feedback_resistor_off,
  output logic sub_feedback_resistor_off
);

  logic [7:0] ctrl_q;
  logic unlock_q;
  logic refused_q;
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic on_sub;
  logic sub_edge;
  logic wr_go;
  logic rd_go;
  logic wr_ctrl;
  logic wr_bit;
  logic wr_prot;
  logic wr_stat;
  logic wr_mapped;
  logic refuse_now;
  logic [7:0] ctrl_rd;
  logic [7:0] bit_new;

  // Register word address check
  function automatic logic is_ofs(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
    is_ofs = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs));
  endfunction

  // Merge a written image; status bit stays hardware-owned, prohibited divider kept
  function automatic logic [7:0] merge_ctrl(input logic [7:0] old, input logic [7:0] nw);
    logic [7:0] r;
    r = nw;
    r[PCK_BIT_ON_SUB] = 1'b0;
    if (nw[PCK_DIV_LSB +: PCK_DIV_W] > PCK_DIV_MAX) begin
      r[PCK_DIV_LSB +: PCK_DIV_W] = old[PCK_DIV_LSB +: PCK_DIV_W];
    end
    merge_ctrl = r;
  endfunction

  // Write channels are taken independently and held until the response;
  // readies drop while ce is low, so no beat is lost into frozen state
  assign s_axi_awready = ce && !aw_full_q && !bvalid_q;
  assign s_axi_wready = ce && !w_full_q && !bvalid_q;
  assign wr_go = ce && aw_full_q && w_full_q && !bvalid_q;
  assign wr_ctrl = wr_go && is_ofs(awaddr_q, PCK_OFS_CTRL);
  assign wr_bit = wr_go && is_ofs(awaddr_q, PCK_OFS_BITOP);
  assign wr_prot = wr_go && is_ofs(awaddr_q, PCK_OFS_PROTECT);
  assign wr_stat = wr_go && is_ofs(awaddr_q, PCK_OFS_STATUS);
  assign wr_mapped = wr_ctrl || wr_bit || wr_prot || wr_stat;
  assign refuse_now = (wr_ctrl || wr_bit) && !unlock_q;

  // Single-bit image: only the indexed bit differs from the current value
  always_comb begin
    bit_new = ctrl_q;
    bit_new[wdata_q[2:0]] = wdata_q[PCK_BITOP_VAL];
  end

  // Write address and data holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response, error for an unmapped word
  // A response seen while ce is low is not retired, so bready must stay up through it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= PCK_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? PCK_RESP_OKAY : PCK_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Unlock lasts for exactly the next write, whatever it targets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_q <= 1'b0;
    end else if (wr_go) begin
      unlock_q <= wr_prot;
    end
  end

  // Control register; the status bit is not stored here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= PCK_CTRL_RESET;
    end else if (unlock_q && wstrb_q[0]) begin
      if (wr_ctrl) begin
        ctrl_q <= merge_ctrl(ctrl_q, wdata_q[7:0]);
      end else if (wr_bit) begin
        ctrl_q <= merge_ctrl(ctrl_q, bit_new);
      end
    end
  end

  // Refused-write flag, write one to clear; a new refusal wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_q <= 1'b0;
    end else if (refuse_now) begin
      refused_q <= 1'b1;
    end else if (wr_stat && wstrb_q[0] && wdata_q[PCK_ST_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  // Read path, one cycle after the address is taken
  assign s_axi_arready = ce && !rvalid_q;
  assign rd_go = ce && s_axi_arvalid && !rvalid_q;

  always_comb begin
    ctrl_rd = ctrl_q;
    ctrl_rd[PCK_BIT_ON_SUB] = on_sub;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= PCK_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= PCK_RESP_OKAY;
        rdata_q <= '0;
        if (is_ofs(s_axi_araddr, PCK_OFS_CTRL)) begin
          rdata_q <= {24'h000000, ctrl_rd};
        end else if (is_ofs(s_axi_araddr, PCK_OFS_STATUS)) begin
          rdata_q <= {29'h00000000, main_osc_stop_out, on_sub != ctrl_q[PCK_BIT_SUB_SEL],
                      refused_q};
        end else if (!is_ofs(s_axi_araddr, PCK_OFS_PROTECT)
                     && !is_ofs(s_axi_araddr, PCK_OFS_BITOP)) begin
          rresp_q <= PCK_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Source switch synchronised to the subclock
  pck_switch u_switch (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sub_sel(ctrl_q[PCK_BIT_SUB_SEL]),
    .sub_clk(sub_clk),
    .cpu_on_sub(on_sub),
    .sub_edge(sub_edge)
  );

  // Internal system clock enable follows the source actually in use
  pck_divider u_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .div_code(ctrl_q[PCK_DIV_LSB +: PCK_DIV_W]),
    .use_sub(on_sub),
    .sub_edge(sub_edge),
    .sys_clk_en(sys_clk_en)
  );

  // Oscillator control; stopping while the CPU still runs on it would hang the core
  assign main_osc_stop_out = stop_mode || (ctrl_q[PCK_BIT_MAIN_OSC_STOP] && on_sub);
  assign main_feedback_resistor_off = ctrl_q[PCK_BIT_MAIN_FB_OFF];
  assign sub_feedback_resistor_off = ctrl_q[PCK_BIT_SUB_FB_OFF];
  assign cpu_clock_is_sub = on_sub;

  a_reset_load: assert property (@(posedge aclk)
    !aresetn |=> (ctrl_q == PCK_CTRL_RESET))
    else $error("control register not loaded with reset value");

  a_locked_write: assert property (@(posedge aclk) disable iff (!aresetn)
    ((wr_ctrl || wr_bit) && !unlock_q) |=> $stable(ctrl_q))
    else $error("control changed by an unprotected write");

  a_unlock_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && !wr_prot) |=> !unlock_q)
    else $error("unlock survived a following write");

  a_bit_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_bit && unlock_q && wstrb_q[0] && wdata_q[2:0] != 3'h4
     && wdata_q[2:0] > 3'h2) |=>
    ((ctrl_q ^ $past(ctrl_q)) & ~(8'h01 << $past(wdata_q[2:0]))) == 8'h00)
    else $error("bit write altered another bit");

  a_bit_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_bit && unlock_q && wstrb_q[0] && wdata_q[2:0] == 3'(PCK_BIT_SUB_SEL)) |=>
    (ctrl_q[PCK_BIT_SUB_SEL] == $past(wdata_q[PCK_BITOP_VAL])))
    else $error("bit write did not reach the addressed bit");

  a_osc_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (!stop_mode && !on_sub) |-> !main_osc_stop_out)
    else $error("main oscillator stopped while CPU on main clock");

  a_osc_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    (stop_mode || (on_sub && ctrl_q[PCK_BIT_MAIN_OSC_STOP])) |-> main_osc_stop_out)
    else $error("main oscillator not stopped when required");

  a_div_legal: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[PCK_DIV_LSB +: PCK_DIV_W] <= PCK_DIV_MAX)
    else $error("prohibited divider code stored");

  a_sub_fb: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && unlock_q && wstrb_q[0]) |=>
    (sub_feedback_resistor_off == $past(wdata_q[PCK_BIT_SUB_FB_OFF])))
    else $error("subclock feedback control does not follow bit 7");

  a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && is_ofs(s_axi_araddr, PCK_OFS_CTRL)) |=>
    (s_axi_rdata[PCK_BIT_ON_SUB] == $past(on_sub)))
    else $error("control read does not show the clock source in use");

endmodule

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pck_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, stop_mode = 0, sub_clk = 0;
  logic [4:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, sys_clk_en, on_sub, osc_off, mfb, sfb;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0] rsp;
  logic [3:0] sdiv = 0;
  int mismatches = 0, tests_run = 0, cycles = 0;

  pck_clock_ctrl i_pck_clock_ctrl (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stop_mode(stop_mode), .sub_clk(sub_clk), .sys_clk_en(sys_clk_en),
    .cpu_clock_is_sub(on_sub), .main_osc_stop_out(osc_off),
    .main_feedback_resistor_off(mfb), .sub_feedback_resistor_off(sfb));

  always #12.5 aclk = ~aclk;

  // Subclock stand-in: period of 16 bus cycles, kept synchronous to aclk
  always @(posedge aclk) begin
    sdiv <= sdiv + 4'h1;
    sub_clk <= sdiv[3];
  end

  // Watchdog: whole run needs under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write: address and data offered together, each released once taken
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (1'b1) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid === 1'b1) begin
        rsp = bresp;
        bready <= 0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (1'b1) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        rsp = rresp;
        rready <= 0;
        break;
      end
    end
  endtask

  // Unlock word then the target write, as software must
  task automatic pwrite(input logic [4:0] a, input logic [31:0] d);
    axi_write(PCK_OFS_PROTECT, 32'h0);
    axi_write(a, d);
  endtask

  task automatic read_ctrl(input logic [7:0] exp);
    axi_read(PCK_OFS_CTRL);
    chk_val("ctrl", {24'h0, exp}, rd);
  endtask

  // Pulses of the system clock enable over 64 cycles
  task automatic count_en(input int exp);
    int k;
    k = 0;
    repeat (64) begin
      @(posedge aclk);
      if (sys_clk_en === 1'b1) k++;
    end
    chk_val("sys_clk_en pulses", exp, k);
  endtask

  task automatic t_reset;
    read_ctrl(8'h03);
    chk_val("sub_fb_off", 0, sfb);
    chk_val("main_fb_off", 0, mfb);
    chk_val("on_sub", 0, on_sub);
    stop_mode <= 1;
    @(posedge aclk);
    #1 chk_val("osc stop in STOP", 1, osc_off);
    @(posedge aclk);
    stop_mode <= 0;
    #1 chk_val("osc run", 0, osc_off);
    $display("test reset done");
  endtask

  task automatic t_protect;
    axi_write(PCK_OFS_CTRL, 32'hA2);
    chk_val("bresp", PCK_RESP_OKAY, rsp);
    read_ctrl(8'h03);
    axi_read(PCK_OFS_STATUS);
    chk_val("refused flag", 1, rd[PCK_ST_REFUSED]);
    axi_write(PCK_OFS_STATUS, 32'h1);
    axi_read(PCK_OFS_STATUS);
    chk_val("refused cleared", 0, rd[PCK_ST_REFUSED]);
    pwrite(PCK_OFS_CTRL, 32'hA2);
    read_ctrl(8'hA2);
    chk_val("sub_fb_off", 1, sfb);
    chk_val("main_fb_off", 1, mfb);
    pwrite(PCK_OFS_CTRL, 32'h03);
    chk_val("sub_fb_off", 0, sfb);
    $display("test protect done");
  endtask

  task automatic t_divider;
    for (int c = 0; c < 6; c++) begin
      pwrite(PCK_OFS_CTRL, c);
      count_en(64 >> c);
    end
    pwrite(PCK_OFS_CTRL, 32'h06);
    read_ctrl(8'h05);
    pwrite(PCK_OFS_CTRL, 32'h03);
    $display("test divider done");
  endtask

  // Stop bit first, then subclock select: oscillator must wait for the switch
  task automatic t_switch;
    int n;
    pwrite(PCK_OFS_BITOP, 32'h0E);
    read_ctrl(8'h43);
    chk_val("osc held on main", 0, osc_off);
    pwrite(PCK_OFS_BITOP, 32'h0C);
    read_ctrl(8'h43);
    pwrite(PCK_OFS_BITOP, 32'h0B);
    n = 0;
    while (on_sub !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk_val("switch in time", 1, n <= 17);
    #1 chk_val("osc stopped on sub", 1, osc_off);
    read_ctrl(8'h5B);
    axi_read(PCK_OFS_STATUS);
    chk_val("status on sub", 32'h4, rd);
    count_en(4);
    axi_write(5'h10, 32'h0);
    chk_val("unmapped bresp", PCK_RESP_SLVERR, rsp);
    axi_read(5'h14);
    chk_val("unmapped rresp", PCK_RESP_SLVERR, rsp);
    $display("test switch done");
  endtask

  // Reset in mid-run while on the subclock: all returns to the reset state
  task automatic t_mid_reset;
    @(posedge aclk);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    read_ctrl(8'h03);
    chk_val("on_sub after reset", 0, on_sub);
    chk_val("osc after reset", 0, osc_off);
    $display("test mid reset done");
  endtask

  // Clock enable low freezes a pending source switch and the system clock enable
  task automatic t_freeze;
    logic held;
    int n;
    pwrite(PCK_OFS_BITOP, 32'h0B);
    ce <= 0;
    @(posedge aclk);
    held = on_sub;
    count_en(0);
    chk_val("on_sub frozen", held, on_sub);
    ce <= 1;
    n = 0;
    while (on_sub !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk_val("switch after freeze", 1, n <= 17);
    $display("test freeze done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_protect();
    t_divider();
    t_switch();
    t_mid_reset();
    t_freeze();
    close_out();
  end
endmodule

`default_nettype wire
